// File: include/temp_result_pkg.sv
// constants, carriers and state layout for the remote temperature result formatter
package temp_result_pkg;

	// command codes, index 0 is remote channel one, index 1 is remote channel two
	localparam logic [1:0][7:0] CMD_SIGNED_INT    = {8'h12, 8'h11};
	localparam logic [1:0][7:0] CMD_UNSIGNED_INT  = {8'h1a, 8'h19};
	localparam logic [1:0][7:0] CMD_SIGNED_FRAC   = {8'h22, 8'h21};
	localparam logic [1:0][7:0] CMD_UNSIGNED_FRAC = {8'h2a, 8'h29};
	localparam logic [1:0][7:0] CMD_CORRECTION    = {8'h32, 8'h31};

	// correction reset value and the byte read at unmapped codes
	localparam logic [7:0] CORRECTION_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ    = 8'h00;

	// raw reading: two's complement in 1/32 degree steps
	localparam int RAW_W = 14;
	localparam int SUM_W = 15;
	localparam int VAL_W = 13;

	// clamp limits of the 13-bit formatted value
	localparam logic [VAL_W-1:0] SIGNED_MAX   = 13'h0fff;
	localparam logic [VAL_W-1:0] SIGNED_MIN   = 13'h1000;
	localparam logic [VAL_W-1:0] UNSIGNED_MAX = 13'h1fff;
	localparam logic [VAL_W-1:0] UNSIGNED_MIN = 13'h0000;

	// format index
	localparam int FMT_SIGNED   = 0;
	localparam int FMT_UNSIGNED = 1;

	typedef struct packed {
		logic             rd;
		logic             wr;
		logic [7:0]       cmd;
		logic [7:0]       wdata;
	} reg_req_t;

	typedef struct packed {
		logic             valid;
		logic [RAW_W-1:0] value;
	} raw_sample_t;

	typedef struct packed {
		logic [1:0][SUM_W-1:0] sum;
		logic [1:0][7:0]       corr;
		logic [1:0][1:0][7:0]  frozen;
		logic [1:0][1:0]       locked;
		logic [7:0]            rd_data;
	} state_t;

endpackage : temp_result_pkg

// File: design/remote_temp_result_format.sv
// remote channel result formatting, correction and fraction freeze
`timescale 1ns/1ns

// Overview of operation
// - signed integer byte: sign then 64..1
// - unsigned integer byte: 128 down to 1
// - fraction bits 7..5 weigh half, quarter, eighth
// - fraction bit 4: sixteenth only when filtering
// - fraction bit 3: thirty-second only when filtering
// - fraction bits 2..0 always read zero
// - per-channel read/write two's-complement correction byte
// - correction spans +63.5 to -64 degrees
// - correction added to raw, reported in results
// - unsigned fraction has its own command code
// - integer read freezes fraction, fraction read releases
// - repeated integer reads refreeze fresh fraction
module remote_temp_result_format
	import temp_result_pkg::*;
(
	// clock and reset
	input  wire logic              clock,
	input  wire logic              reset_n,
	// command access from the serial bus engine
	input  wire reg_req_t          req,
	output logic [7:0]             rd_data,
	// converter results, index 0 is channel one
	input  wire raw_sample_t [1:0] raw,
	// filter selections from the filter setting
	input  wire logic [1:0]        channel_one_filter_select,
	input  wire logic [1:0]        channel_two_filter_select
);

	state_t q;
	state_t n;

	logic [1:0]                  filt_on;
	logic [1:0][1:0][VAL_W-1:0]  val;
	logic [1:0][1:0][7:0]        int_byte;
	logic [1:0][1:0][7:0]        live_frac;
	logic [1:0][1:0][7:0]        frac_out;
	logic [1:0][SUM_W-1:0]       corrected;

	function automatic logic [VAL_W-1:0] clamp_value(input logic [SUM_W-1:0] s, input logic uns);
		logic [VAL_W-1:0] v;
		v = s[VAL_W-1:0];
		if (uns)
		begin
			if (s[SUM_W-1])
				v = UNSIGNED_MIN;
			else if (s[SUM_W-2])
				v = UNSIGNED_MAX;
		end
		else if (!((s[SUM_W-1:VAL_W-1] == 3'b000) || (s[SUM_W-1:VAL_W-1] == 3'b111)))
		begin
			v = s[SUM_W-1] ? SIGNED_MIN : SIGNED_MAX;
		end
		return v;
	endfunction : clamp_value

	// extra resolution is masked, not rounded, when the filter is off
	function automatic logic [7:0] frac_byte(input logic [VAL_W-1:0] v, input logic filt);
		return {v[4:2], (filt ? v[1:0] : 2'b00), 3'b000};
	endfunction : frac_byte

	assign filt_on[0] = |channel_one_filter_select;
	assign filt_on[1] = |channel_two_filter_select;
	assign rd_data    = q.rd_data;

	for (genvar ch = 0; ch < 2; ch++)
	begin : g_chan
		// correction is in half degrees, the reading in 1/32 degree
		assign corrected[ch] = {raw[ch].value[RAW_W-1], raw[ch].value}
			+ {{3{q.corr[ch][7]}}, q.corr[ch], 4'h0};
		for (genvar f = 0; f < 2; f++)
		begin : g_fmt
			assign val[ch][f]       = clamp_value(q.sum[ch], f == FMT_UNSIGNED);
			assign int_byte[ch][f]  = val[ch][f][VAL_W-1:5];
			assign live_frac[ch][f] = frac_byte(val[ch][f], filt_on[ch]);
			assign frac_out[ch][f]  = q.locked[ch][f] ? q.frozen[ch][f] : live_frac[ch][f];
		end
	end

	always_comb
	begin
		n = q;
		for (int ch = 0; ch < 2; ch++)
		begin
			if (raw[ch].valid)
				n.sum[ch] = corrected[ch];
			if (req.wr && req.cmd == CMD_CORRECTION[ch])
				n.corr[ch] = req.wdata;
		end
		if (req.rd)
		begin
			n.rd_data = UNMAPPED_READ;
			for (int ch = 0; ch < 2; ch++)
			begin
				if (req.cmd == CMD_CORRECTION[ch])
					n.rd_data = q.corr[ch];
				for (int f = 0; f < 2; f++)
				begin
					if (req.cmd == (f == FMT_SIGNED ? CMD_SIGNED_INT[ch] : CMD_UNSIGNED_INT[ch]))
					begin
						n.rd_data        = int_byte[ch][f];
						n.frozen[ch][f]  = live_frac[ch][f];
						n.locked[ch][f]  = 1'b1;
					end
					if (req.cmd == (f == FMT_SIGNED ? CMD_SIGNED_FRAC[ch] : CMD_UNSIGNED_FRAC[ch]))
					begin
						n.rd_data        = frac_out[ch][f];
						n.locked[ch][f]  = 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			q         <= '0;
			q.corr[0] <= CORRECTION_RESET;
			q.corr[1] <= CORRECTION_RESET;
		end
		else
			q <= n;
	end

	// checks mostly on channel one; channel two shares the same generate body
	logic rd_sint;
	logic rd_uint;
	logic rd_sfrac;
	logic rd_ufrac;
	assign rd_sint  = req.rd && req.cmd == CMD_SIGNED_INT[0];
	assign rd_uint  = req.rd && req.cmd == CMD_UNSIGNED_INT[0];
	assign rd_sfrac = req.rd && req.cmd == CMD_SIGNED_FRAC[0];
	assign rd_ufrac = req.rd && req.cmd == CMD_UNSIGNED_FRAC[0];

	property p_signed_sign;
		@(posedge clock) disable iff (!reset_n)
		rd_sint |=> rd_data[7] == $past(q.sum[0][SUM_W-1]);
	endproperty
	a_signed_sign: assert property (p_signed_sign) else $error("signed integer sign wrong");

	property p_unsigned_floor;
		@(posedge clock) disable iff (!reset_n)
		(rd_uint && q.sum[0][SUM_W-1]) |=> rd_data == 8'h00;
	endproperty
	a_unsigned_floor: assert property (p_unsigned_floor) else $error("negative not floored");

	property p_frac_top;
		@(posedge clock) disable iff (!reset_n)
		(rd_sfrac && !q.locked[0][0] && q.sum[0][SUM_W-1:VAL_W-1] == 3'b000)
		|=> rd_data[7:5] == $past(q.sum[0][4:2]);
	endproperty
	a_frac_top: assert property (p_frac_top) else $error("fraction weights wrong");

	property p_filter_off_mask;
		@(posedge clock) disable iff (!reset_n)
		(rd_sfrac && !q.locked[0][0] && channel_one_filter_select == 2'b00) |=> rd_data[4:3] == 2'b00;
	endproperty
	a_filter_off_mask: assert property (p_filter_off_mask) else $error("fine bits not masked");

	property p_filter_on_bits;
		@(posedge clock) disable iff (!reset_n)
		(rd_ufrac && !q.locked[0][1] && channel_one_filter_select != 2'b00
			&& q.sum[0][SUM_W-1:SUM_W-2] == 2'b00)
		|=> rd_data[4:3] == $past(q.sum[0][1:0]);
	endproperty
	a_filter_on_bits: assert property (p_filter_on_bits) else $error("fine bits missing");

	property p_reserved_zero;
		@(posedge clock) disable iff (!reset_n)
		(rd_sfrac || rd_ufrac) |=> rd_data[2:0] == 3'b000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

	property p_corr_readback;
		@(posedge clock) disable iff (!reset_n)
		(req.wr && req.cmd == CMD_CORRECTION[0]) ##1 !req.wr ##1 (req.rd && !req.wr && req.cmd == CMD_CORRECTION[0])
		|=> rd_data == $past(req.wdata, 3);
	endproperty
	a_corr_readback: assert property (p_corr_readback) else $error("correction readback wrong");

	property p_corr_added;
		@(posedge clock) disable iff (!reset_n)
		raw[0].valid |=> $signed(q.sum[0]) == $signed($past(raw[0].value))
			+ 16 * $signed($past(q.corr[0]));
	endproperty
	a_corr_added: assert property (p_corr_added) else $error("correction not applied");

	property p_freeze;
		@(posedge clock) disable iff (!reset_n)
		rd_sint ##1 (!rd_sint && !rd_sfrac)[*3] ##1 rd_sfrac |=> rd_data == $past(q.frozen[0][0]);
	endproperty
	a_freeze: assert property (p_freeze) else $error("frozen fraction not returned");

	property p_release;
		@(posedge clock) disable iff (!reset_n)
		rd_ufrac |=> !q.locked[0][1];
	endproperty
	a_release: assert property (p_release) else $error("fraction not released");

	property p_refreeze;
		@(posedge clock) disable iff (!reset_n)
		rd_sint |=> q.locked[0][0] && q.frozen[0][0] == $past(live_frac[0][0]);
	endproperty
	a_refreeze: assert property (p_refreeze) else $error("fresh fraction not frozen");

	property p_filter_enable;
		@(posedge clock) disable iff (!reset_n)
		(req.rd && req.cmd == CMD_UNSIGNED_FRAC[1] && !q.locked[1][1] && channel_two_filter_select != 2'b00
			&& q.sum[1][SUM_W-1:SUM_W-2] == 2'b00)
		|=> rd_data[4:3] == $past(q.sum[1][1:0]);
	endproperty
	a_filter_enable: assert property (p_filter_enable) else $error("filter enable decode wrong");

	c_int_then_frac: cover property (@(posedge clock) disable iff (!reset_n) rd_sint ##[1:4] rd_sfrac);
	c_corr_write:    cover property (@(posedge clock) disable iff (!reset_n)
		req.wr && req.cmd == CMD_CORRECTION[1]);
	c_filtered_frac: cover property (@(posedge clock) disable iff (!reset_n)
		rd_ufrac && channel_one_filter_select != 2'b00);
	c_refreeze:      cover property (@(posedge clock) disable iff (!reset_n) rd_sint ##[2:4] rd_sint);

endmodule : remote_temp_result_format

// File: sim/host_model.sv
// host side model issuing register reads and writes on the command port
`timescale 1ns/1ns
module host_model
	import temp_result_pkg::*;
(
	// clock
	input  wire logic       clock,
	// command port
	output reg_req_t        req,
	input  wire logic [7:0] rd_data
);
	initial req = '0;

	// code and data are scrambled after the taking edge so nothing stale is reused
	task host_read(input logic [7:0] c, output logic [7:0] d);
		@(posedge clock);
		req.rd <= 1'b1;
		req.cmd <= c;
		@(posedge clock);
		req.rd <= 1'b0;
		req.cmd <= ~c;
		#1 d = rd_data;
	endtask : host_read

	task host_write(input logic [7:0] c, input logic [7:0] v);
		@(posedge clock);
		req.wr <= 1'b1;
		req.cmd <= c;
		req.wdata <= v;
		@(posedge clock);
		req.wr <= 1'b0;
		req.cmd <= ~c;
		req.wdata <= ~v;
	endtask : host_write
endmodule : host_model

// File: sim/remote_temp_result_format_tb.sv
// self-checking bench for the remote temperature result formatter
`timescale 1ns/1ns
module remote_temp_result_format_tb;
	import temp_result_pkg::*;
	logic              clock;
	logic              reset_n;
	reg_req_t          req;
	logic [7:0]        rd_data;
	raw_sample_t [1:0] raw;
	logic [1:0]        channel_one_filter_select;
	logic [1:0]        channel_two_filter_select;
	int                err_count;
	int                num_checks;
	int                corr [2];
	int                targets [3];
	int                order [6];
	logic [7:0]        d;

	remote_temp_result_format uut (.clock(clock), .reset_n(reset_n), .req(req), .rd_data(rd_data), .raw(raw),
		.channel_one_filter_select(channel_one_filter_select), .channel_two_filter_select(channel_two_filter_select));
	host_model host (.clock(clock), .req(req), .rd_data(rd_data));

	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task report_and_stop;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	task rd_check(input logic [7:0] c, input logic [7:0] exp);
		host.host_read(c, d);
		check(d, exp);
	endtask : rd_check

	task wr_corr(input int ch, input int v);
		corr[ch] = v;
		host.host_write(CMD_CORRECTION[ch], 8'(v));
		rd_check(CMD_CORRECTION[ch], 8'(v));
	endtask : wr_corr

	// s is the wanted sum in 1/32 degree; raw is backed off by the correction in half degrees
	task set_raw(input int ch, input int s, input logic [1:0] f);
		@(posedge clock);
		channel_one_filter_select <= f;
		channel_two_filter_select <= f;
		raw[ch].valid <= 1'b1;
		raw[ch].value <= 14'(s - corr[ch] * 16);
		@(posedge clock);
		raw[ch].valid <= 1'b0;
		raw[ch].value <= ~raw[ch].value;
	endtask : set_raw

	function logic [7:0] expect_byte(int s, bit uns, bit frac, bit filt);
		logic [12:0] v;
		if (uns && s < 0)
			s = 0;
		if (!uns && s > 4095)
			s = 4095;
		v = 13'(s);
		return frac ? {v[4:2], filt ? v[1:0] : 2'b00, 3'b000} : v[12:5];
	endfunction : expect_byte

	function logic [7:0] cmd_of(int ch, int k);
		case (k)
			0: return CMD_SIGNED_INT[ch];
			1: return CMD_SIGNED_FRAC[ch];
			2: return CMD_UNSIGNED_INT[ch];
			default: return CMD_UNSIGNED_FRAC[ch];
		endcase
	endfunction : cmd_of

	initial
	begin
		repeat (3000) @(posedge clock);
		err_count++;
		report_and_stop;
	end

	initial
	begin
		reset_n = 1'b0;
		raw = '0;
		channel_one_filter_select = 2'b00;
		channel_two_filter_select = 2'b00;
		err_count = 0;
		num_checks = 0;
		corr = '{0, 0};
		targets = '{32'h0e7f, -1, 32'h1055};
		// unlocked fraction reads first, then each integer read followed by its fraction
		order = '{1, 3, 0, 1, 2, 3};
		repeat (6) @(posedge clock);
		reset_n <= 1'b1;
		rd_check(CMD_CORRECTION[0], CORRECTION_RESET);
		rd_check(CMD_CORRECTION[1], CORRECTION_RESET);
		rd_check(8'h13, UNMAPPED_READ);
		// extremes of the correction span, one per channel
		wr_corr(0, -128);
		wr_corr(1, 127);
		host.host_write(CMD_SIGNED_INT[0], 8'h55);
		rd_check(CMD_CORRECTION[0], 8'h80);
		for (int ch = 0; ch < 2; ch++)
			foreach (targets[t])
				for (int f = 0; f < 4; f++)
				begin
					set_raw(ch, targets[t], 2'(f));
					foreach (order[k])
						rd_check(cmd_of(ch, order[k]),
							expect_byte(targets[t], order[k] > 1, order[k][0], f != 0));
				end
		// host breaks integer-before-fraction order here, reading the signed fraction twice
		set_raw(0, 32'h0e7f, 2'd3);
		rd_check(CMD_SIGNED_INT[0], 8'h73);
		rd_check(CMD_UNSIGNED_INT[0], 8'h73);
		set_raw(0, 32'h0e60, 2'd3);
		rd_check(CMD_SIGNED_FRAC[0], 8'hf8);
		rd_check(CMD_SIGNED_FRAC[0], 8'h00);
		rd_check(CMD_UNSIGNED_FRAC[0], 8'hf8);
		rd_check(CMD_SIGNED_INT[0], 8'h73);
		set_raw(0, 32'h0e75, 2'd3);
		rd_check(CMD_SIGNED_INT[0], 8'h73);
		set_raw(0, 32'h0e7f, 2'd3);
		rd_check(CMD_SIGNED_FRAC[0], 8'ha8);
		// reset in mid-run returns correction and stored sum to their reset values
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		rd_check(CMD_CORRECTION[0], CORRECTION_RESET);
		rd_check(CMD_SIGNED_INT[0], 8'h00);
		report_and_stop;
	end
endmodule : remote_temp_result_format_tb
